//--- hw/fe_cfg_pkg.sv
/*
  fe_cfg_pkg: register indices, field positions, codes and the output
  bundle of the front-end clock and switch configuration bank.
  Assumes one system clock; the bank and its testbench are the users of these names.
*/
package fe_cfg_pkg;

  // register indices on the configuration port
  localparam logic [3:0] ADDR_OSC    = 4'h4;  // oscillator_control
  localparam logic [3:0] ADDR_MEMDIV = 4'h5;  // memory_clock_divider
  localparam logic [3:0] ADDR_HFSRC  = 4'h6;  // hf_clock_source
  localparam logic [3:0] ADDR_TRIG   = 4'h7;  // trigger_symmetry_control
  localparam logic [3:0] ADDR_DCHG   = 4'h8;  // discharge_resistor_control
  localparam logic [3:0] ADDR_CHGAUX = 4'h9;  // charge_aux_control
  localparam logic [3:0] ADDR_SENSOR = 4'hA;  // sensor_mode_flags
  localparam int         NUM_REGS    = 7;
  localparam logic [7:0] REG_RESET   = 8'h00;

  // oscillator_control fields
  localparam int OSC_DIS_BIT   = 7;
  localparam int OSC_GAIN_BIT  = 6;
  localparam int OSC_QDIV_BIT  = 5;
  localparam int OSC_AUTO_BIT  = 4;
  localparam int OSC_HALT_BIT  = 3;
  localparam int OSC_RUN_LSB   = 0;

  // run policy codes and warm-up lengths in low-frequency periods
  localparam logic [2:0] RUN_STOP   = 3'h0;
  localparam logic [2:0] RUN_CONT   = 3'h1;
  localparam logic [2:0] RUN_LAT31  = 3'h2;
  localparam logic [2:0] RUN_LAT2   = 3'h3;
  localparam logic [2:0] RUN_LAT1   = 3'h6;
  localparam logic [4:0] LAT_SHORT  = 5'h01;
  localparam logic [4:0] LAT_MID    = 5'h02;
  localparam logic [4:0] LAT_LONG   = 5'h1F;
  localparam logic [1:0] QDIV_LAST  = 2'h3;

  // memory clock divider field
  localparam int         MEMDIV_W   = 6;

  // hf source codes
  localparam logic [2:0] HF_INT1 = 3'h1;
  localparam logic [2:0] HF_INT2 = 3'h2;
  localparam logic [2:0] HF_EXT  = 3'h4;

  // hf_clock_source and trigger_symmetry_control fields
  localparam int HF_SEL_LSB   = 0;
  localparam int TRG_DUM_BIT  = 4;
  localparam int TRG_SYM_BIT  = 3;
  localparam int TRG_INV_BIT  = 2;
  localparam int TRG_SEL_LSB  = 0;

  // discharge_resistor_control fields
  localparam int DCH_UP_LSB   = 6;
  localparam int DCH_LO_LSB   = 4;
  localparam int DCH_INT_BIT  = 3;
  localparam int DCH_EXT_BIT  = 1;
  localparam int DCH_MEG_BIT  = 0;

  // charge_aux_control fields
  localparam int AUX_PD_BIT   = 6;
  localparam int AUX_CAP_BIT  = 5;
  localparam int ERLY_BIT     = 4;
  localparam int HOLD_BIT     = 3;
  localparam int XHOLD_BIT    = 2;
  localparam int CHG_SEL_LSB  = 0;

  // sensor_mode_flags fields
  localparam int SNS_FLT_BIT  = 0;
  localparam int SNS_MISC_LSB = 1;

  // outputs that steer the analog front end
  typedef struct packed {
    logic       hfInt1;
    logic       hfInt2;
    logic       hfExt;
    logic       dummyOn;
    logic       trigSym;
    logic       senseInvert;
    logic [1:0] trigSel;
    logic [3:0] upperRes;
    logic [3:0] lowerRes;
    logic       megOn;
    logic       dchgIntOn;
    logic       dchgExtOn;
    logic       auxActive;
    logic       auxCapInt;
    logic       earlyRelease;
    logic       holdOn;
    logic       extHold;
    logic [3:0] chargeRes;
    logic       floating;
    logic [6:0] sensorMisc;
  } feCtrl_s;

  // state of the oscillator warm-up sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WARM = 2'b01,
    ST_MEAS = 2'b11
  } warm_e;

endpackage

//--- hw/frontend_clock_config_regs.sv
/*
  frontend_clock_config_regs: configuration registers 4 to 10 of the
  capacitance front end, the external oscillator gate with warm-up
  sequencing, the quarter divider and the memory clock divider.
  Assumes the external oscillator and low-frequency clock arrive as
  asynchronous pin levels, and that the register port and measurement
  handshake are driven from sys_clk logic.
*/
// Behaviour
// - disable bit set shuts the oscillator off
// - gain trim selects low or high gain
// - quarter bit divides oscillator ticks by four
// - run code 0 stops, 1 runs always
// - pulsed codes warm up 1, 2, 31 periods
// - memory clock divides low clock by 1..126
// - hf source codes 1, 2, 4 select sources
// - dummy symmetry on when bit cleared
// - upper ports discharge resistor code select
// - lower and special ports resistor select
// - enables switch on-chip and off-chip discharge
// - megohm bit replaces lower path resistor only
// - aux pull-down off bit activates port
// - early release, hold, external hold controls
// - charging resistor one of four codes
// - sensor flag bit zero selects floating
`timescale 1ns/1ns
module frontend_clock_config_regs
  import fe_cfg_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // configuration port
  input  wire logic             cfgWrEn,
  input  wire logic [3:0]       cfgAddr,
  input  wire logic [7:0]       cfgWrData,
  output logic      [7:0]       cfgRdData,
  // asynchronous clock pins
  input  wire logic             extOscPin,
  input  wire logic             lfClkPin,
  // measurement handshake
  input  wire logic             measReq,
  input  wire logic             measDone,
  output logic                  measGo,
  output logic                  measReady,
  // clock generator controls
  output logic                  oscEnable,
  output logic                  oscGainHigh,
  output logic                  oscTick,
  output logic                  memClkEn,
  // analog front-end switches
  output fe_cfg_pkg::feCtrl_s   feCtrl
);
  import fe_cfg_pkg::*;

  // one-hot select for the four-way resistor ladders
  function automatic logic [3:0] resOneHot(input logic [1:0] code);
    resOneHot = 4'h1 << code;
  endfunction

  // register storage, index 0 is oscillator_control
  logic [7:0]  regs_ff [NUM_REGS];
  logic [3:0]  regAddr [NUM_REGS];
  assign regAddr[0] = ADDR_OSC;
  assign regAddr[1] = ADDR_MEMDIV;
  assign regAddr[2] = ADDR_HFSRC;
  assign regAddr[3] = ADDR_TRIG;
  assign regAddr[4] = ADDR_DCHG;
  assign regAddr[5] = ADDR_CHGAUX;
  assign regAddr[6] = ADDR_SENSOR;

  // every register is a plain byte, written whole, reset to zero
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          regs_ff[gi] <= REG_RESET;
        end else if (cfgWrEn && cfgAddr == regAddr[gi]) begin
          regs_ff[gi] <= cfgWrData;
        end
      end
    end
  endgenerate

  // read mux; unmapped indices answer zero
  logic [7:0] nxt_rdData;
  always_comb begin
    nxt_rdData = 8'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (cfgAddr == regAddr[i]) begin
        nxt_rdData = regs_ff[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfgRdData <= REG_RESET;
    end else begin
      cfgRdData <= nxt_rdData;
    end
  end

  // named views of the register fields
  wire [7:0] oscReg   = regs_ff[0];
  wire [7:0] memReg   = regs_ff[1];
  wire [7:0] hfReg    = regs_ff[2];
  wire [7:0] trigReg  = regs_ff[3];
  wire [7:0] dchgReg  = regs_ff[4];
  wire [7:0] chgReg   = regs_ff[5];
  wire [7:0] sensReg  = regs_ff[6];
  wire       oscOff   = oscReg[OSC_DIS_BIT];
  wire       quarter  = oscReg[OSC_QDIV_BIT];
  wire [2:0] runCode  = oscReg[OSC_RUN_LSB +: 3];
  // reserved bits 4 and 3 are only stored and read back
  // nothing decodes them, so a write there cannot move the oscillator
  wire [MEMDIV_W-1:0] memCode = memReg[MEMDIV_W-1:0];
  // source and resistor select codes
  wire [2:0] hfSel    = hfReg[HF_SEL_LSB +: 3];
  wire [1:0] upCode   = dchgReg[DCH_UP_LSB +: 2];
  wire [1:0] loCode   = dchgReg[DCH_LO_LSB +: 2];
  wire [1:0] chgCode  = chgReg[CHG_SEL_LSB +: 2];
  wire       megSel   = dchgReg[DCH_MEG_BIT];

  // pulsed policy and its warm-up length in low-frequency periods
  logic       pulsed;
  logic [4:0] latency;
  always_comb begin
    pulsed  = 1'b1;
    latency = LAT_SHORT;
    case (runCode)
      RUN_LAT1:  latency = LAT_SHORT;
      RUN_LAT2:  latency = LAT_MID;
      RUN_LAT31: latency = LAT_LONG;
      default:   pulsed  = 1'b0;
    endcase
  end
  wire contMode = (runCode == RUN_CONT) && !oscOff;
  wire pulseOk  = pulsed && !oscOff;

  // three-stage synchronisers; a level counts once stages 2 and 3 agree
  logic [2:0] extSync_ff;
  logic [2:0] lfSync_ff;
  logic       extLvl_ff;
  logic       lfLvl_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      extSync_ff <= 3'h0;
      lfSync_ff  <= 3'h0;
      extLvl_ff  <= 1'b0;
      lfLvl_ff   <= 1'b0;
    end else begin
      extSync_ff <= {extSync_ff[1:0], extOscPin};
      lfSync_ff  <= {lfSync_ff[1:0], lfClkPin};
      if (extSync_ff[1] == extSync_ff[2]) begin
        extLvl_ff <= extSync_ff[2];
      end
      if (lfSync_ff[1] == lfSync_ff[2]) begin
        lfLvl_ff <= lfSync_ff[2];
      end
    end
  end
  // rising edges of the filtered levels
  wire extRise = (extSync_ff[1] == extSync_ff[2]) && extSync_ff[2] &&
                 !extLvl_ff;
  wire lfTick = (lfSync_ff[1] == lfSync_ff[2]) && lfSync_ff[2] && !lfLvl_ff;

  // warm-up sequencer: pulsed mode starts the oscillator per measurement
  warm_e      state_ff;
  warm_e      nxt_state;
  logic [4:0] warmCnt_ff;
  logic [4:0] nxt_warmCnt;
  wire        warmDone = lfTick && (warmCnt_ff == latency - LAT_SHORT);
  always_comb begin
    nxt_state   = state_ff;
    nxt_warmCnt = warmCnt_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_warmCnt = 5'h00;
        if (measReq && contMode) begin
          nxt_state = ST_MEAS;
        end else if (measReq && pulseOk) begin
          nxt_state = ST_WARM;
        end
      end
      ST_WARM: begin
        // leaving the pulsed codes or setting disable mid warm-up abandons the measurement
        if (!pulseOk) begin
          nxt_state = ST_IDLE;
        end else if (warmDone) begin
          nxt_state = ST_MEAS;
        end else if (lfTick) begin
          nxt_warmCnt = warmCnt_ff + 5'h01;
        end
      end
      ST_MEAS: begin
        if (measDone || oscOff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      warmCnt_ff <= 5'h00;
    end else begin
      state_ff   <= nxt_state;
      warmCnt_ff <= nxt_warmCnt;
    end
  end

  // oscillator gate: disable wins, then continuous, then pulsed window
  wire nxt_oscEnable = !oscOff &&
                       (contMode || (pulseOk && nxt_state != ST_IDLE));
  wire nxt_measGo    = (nxt_state == ST_MEAS) && (state_ff != ST_MEAS);

  // quarter divider counts oscillator edges only while running
  logic [1:0] qCnt_ff;
  wire        qHit = !quarter || (qCnt_ff == QDIV_LAST);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      qCnt_ff <= 2'h0;
      oscTick <= 1'b0;
    end else begin
      oscTick <= oscEnable && extRise && qHit;
      if (!oscEnable || !quarter) begin
        qCnt_ff <= 2'h0;
      end else if (extRise) begin
        qCnt_ff <= qCnt_ff + 2'h1;
      end
    end
  end

  // memory clock: divide by 1 at code 0, otherwise by twice the code
  logic [6:0] memCnt_ff;
  wire  [6:0] memDiv  = (memCode == '0) ? 7'h01 : {memCode, 1'b0};
  wire        memWrap = (memCnt_ff + 7'h01) >= memDiv;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memCnt_ff <= 7'h00;
      memClkEn  <= 1'b0;
    end else begin
      memClkEn <= lfTick && memWrap;
      if (lfTick) begin
        memCnt_ff <= memWrap ? 7'h00 : memCnt_ff + 7'h01;
      end
    end
  end

  // front-end decode; divider setting for 35 kHz is left to software
  feCtrl_s nxt_feCtrl;
  always_comb begin
    nxt_feCtrl              = '0;
    nxt_feCtrl.hfInt1       = hfSel == HF_INT1;
    nxt_feCtrl.hfInt2       = hfSel == HF_INT2;
    nxt_feCtrl.hfExt        = hfSel == HF_EXT;
    nxt_feCtrl.dummyOn      = !trigReg[TRG_DUM_BIT];
    nxt_feCtrl.trigSym      = trigReg[TRG_SYM_BIT];
    nxt_feCtrl.senseInvert  = trigReg[TRG_INV_BIT];
    nxt_feCtrl.trigSel      = trigReg[TRG_SEL_LSB +: 2];
    nxt_feCtrl.upperRes     = resOneHot(upCode);
    // the megohm path removes the kilo-ohm ladder from lower ports only
    nxt_feCtrl.megOn        = megSel;
    nxt_feCtrl.lowerRes     = megSel ? 4'h0 :
                              resOneHot(loCode);
    nxt_feCtrl.dchgIntOn    = dchgReg[DCH_INT_BIT];
    nxt_feCtrl.dchgExtOn    = dchgReg[DCH_EXT_BIT];
    nxt_feCtrl.auxActive    = chgReg[AUX_PD_BIT];
    nxt_feCtrl.auxCapInt    = chgReg[AUX_CAP_BIT];
    nxt_feCtrl.earlyRelease = chgReg[ERLY_BIT];
    nxt_feCtrl.holdOn       = chgReg[HOLD_BIT];
    nxt_feCtrl.extHold      = chgReg[XHOLD_BIT];
    nxt_feCtrl.chargeRes    = resOneHot(chgCode);
    nxt_feCtrl.floating     = sensReg[SNS_FLT_BIT];
    nxt_feCtrl.sensorMisc   = sensReg[SNS_MISC_LSB +: 7];
  end

  // all top-level outputs leave from flip-flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oscEnable   <= 1'b0;
      oscGainHigh <= 1'b0;
      measGo      <= 1'b0;
      measReady   <= 1'b0;
      feCtrl      <= '0;
    end else begin
      oscEnable   <= nxt_oscEnable;
      oscGainHigh <= oscReg[OSC_GAIN_BIT];
      measGo      <= nxt_measGo;
      measReady   <= nxt_state == ST_MEAS;
      feCtrl      <= nxt_feCtrl;
    end
  end

  // checks
  AST_OSC_OFF: assert property (
    @(posedge sys_clk) disable iff (rst) oscOff |=> !oscEnable)
    else $error("oscillator enabled while disabled");

  AST_GAIN_WRITE: assert property (
    @(posedge sys_clk) disable iff (rst)
    cfgWrEn && cfgAddr == ADDR_OSC |-> ##2
    oscGainHigh == $past(cfgWrData[OSC_GAIN_BIT], 2))
    else $error("gain output does not follow write");

  AST_QUARTER_SKIP: assert property (
    @(posedge sys_clk) disable iff (rst)
    extRise && quarter && qCnt_ff != QDIV_LAST |=> !oscTick)
    else $error("quarter divider ticked early");

  AST_CONT_RUN: assert property (
    @(posedge sys_clk) disable iff (rst)
    contMode |=> oscEnable)
    else $error("continuous mode not running");

  AST_STOP_IDLE: assert property (
    @(posedge sys_clk) disable iff (rst)
    runCode == RUN_STOP && state_ff == ST_IDLE && !measReq |=> !oscEnable)
    else $error("oscillator running in stop code");

  AST_WARM_END: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_ff == ST_WARM && pulseOk && warmDone |=>
    state_ff == ST_MEAS && measGo && oscEnable)
    else $error("warm-up did not end in measurement");

  AST_WARM_HOLD: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_ff == ST_WARM && !lfTick && pulseOk |=> state_ff == ST_WARM)
    else $error("warm-up left without a low clock edge");

  AST_MEM_DIV1: assert property (
    @(posedge sys_clk) disable iff (rst)
    memCode == '0 && lfTick |=> memClkEn)
    else $error("divide by one missed a tick");

  AST_HF_EXT: assert property (
    @(posedge sys_clk) disable iff (rst)
    hfSel == HF_EXT |=> feCtrl.hfExt && !feCtrl.hfInt1)
    else $error("external hf source not selected");

  AST_MEG_LOWER: assert property (
    @(posedge sys_clk) disable iff (rst)
    feCtrl.megOn |-> feCtrl.lowerRes == 4'h0 && feCtrl.upperRes != 4'h0)
    else $error("megohm option touched the wrong ladder");

endmodule

//--- tb/testbench.sv
/*
  testbench: self-checking bench for frontend_clock_config_regs.
  Assumes fe_cfg_pkg is compiled first; the bench drives every input
  on the falling edge and toggles both clock pins itself.
*/
`timescale 1ns/1ns
module testbench;
  import fe_cfg_pkg::*;

  // one row: register index, written byte, byte expected on read
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_s;

  logic         sys_clk;      // 10 MHz system clock
  logic         rst;          // synchronous reset
  logic         cfgWrEn;      // write strobe
  logic [3:0]   cfgAddr;      // register index
  logic [7:0]   cfgWrData;    // write byte
  logic [7:0]   cfgRdData;    // read byte
  logic         extOscPin;    // raw oscillator pin
  logic         lfClkPin;     // low-frequency clock pin
  logic         measReq;      // measurement request
  logic         measDone;     // measurement finished
  logic         measGo;       // start pulse
  logic         measReady;    // measuring level
  logic         oscEnable;    // oscillator run
  logic         oscGainHigh;  // gain trim out
  logic         oscTick;      // oscillator tick
  logic         memClkEn;     // memory clock pulse
  feCtrl_s      feCtrl;       // front-end switch bundle
  logic [7:0]   sh [4:10];    // shadow of the bank
  int           n_fail;       // mismatches
  int           cmp_count;    // comparisons
  row_s         rows [16];    // ordinary write/read cases

  frontend_clock_config_regs uut (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .cfgWrEn     (cfgWrEn),
    .cfgAddr     (cfgAddr),
    .cfgWrData   (cfgWrData),
    .cfgRdData   (cfgRdData),
    .extOscPin   (extOscPin),
    .lfClkPin    (lfClkPin),
    .measReq     (measReq),
    .measDone    (measDone),
    .measGo      (measGo),
    .measReady   (measReady),
    .oscEnable   (oscEnable),
    .oscGainHigh (oscGainHigh),
    .oscTick     (oscTick),
    .memClkEn    (memClkEn),
    .feCtrl      (feCtrl)
  );

  // system clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // pins run free, toggling on falling edges: lf period 20, osc 8 cycles
  always #1000 lfClkPin = ~lfClkPin;
  always #400 extOscPin = ~extOscPin;

  // expected switch bundle, worked out from the shadow bytes
  function automatic feCtrl_s expFe();
    feCtrl_s e;
    e = '0;
    e.hfInt1 = (sh[6][2:0] == HF_INT1);
    e.hfInt2 = (sh[6][2:0] == HF_INT2);
    e.hfExt = (sh[6][2:0] == HF_EXT);
    e.dummyOn = ~sh[7][4];
    e.trigSym = sh[7][3];
    e.senseInvert = sh[7][2];
    e.trigSel = sh[7][1:0];
    e.upperRes = 4'h1 << sh[8][7:6];
    // megohm path replaces only the lower-port resistor
    e.lowerRes = sh[8][0] ? 4'h0 : (4'h1 << sh[8][5:4]);
    e.megOn = sh[8][0];
    e.dchgIntOn = sh[8][3];
    e.dchgExtOn = sh[8][1];
    e.auxActive = sh[9][6];
    e.auxCapInt = sh[9][5];
    e.earlyRelease = sh[9][4];
    e.holdOn = sh[9][3];
    e.extHold = sh[9][2];
    e.chargeRes = 4'h1 << sh[9][1:0];
    e.floating = sh[10][0];
    e.sensorMisc = sh[10][7:1];
    return e;
  endfunction

  // pulse output picked by index
  function automatic logic pick(input int sel);
    case (sel)
      0: return measGo;
      1: return oscTick;
      default: return memClkEn;
    endcase
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write; the extra edge keeps strobes from merging back to back
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cfgAddr = a;
    cfgWrData = d;
    cfgWrEn = 1'b1;
    @(negedge sys_clk);
    cfgWrEn = 1'b0;
    if (a >= ADDR_OSC && a <= ADDR_SENSOR) sh[a] = d;
    @(negedge sys_clk);
  endtask

  // read data is registered, so look two cycles later
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    cfgAddr = a;
    repeat (2) @(negedge sys_clk);
    chk(cfgRdData, e);
  endtask

  task automatic check_all();
    for (int a = 4; a <= 10; a++) rd(a[3:0], sh[a]);
    chk({oscGainHigh, feCtrl}, {sh[4][6], expFe()});
  endtask

  // bounded wait for a pulse; n is -1 if it never came
  task automatic wait_sig(input int sel, input int first, input int lim,
                          output int n);
    n = -1;
    for (int i = first; i <= lim; i++) begin
      if (i > 0) @(negedge sys_clk);
      if (pick(sel) === 1'b1) begin
        n = i;
        break;
      end
    end
  endtask

  // distance in cycles between two later pulses of one output
  task automatic period(input int sel, input int exp, input int lim);
    int n;
    repeat (2) wait_sig(sel, 1, lim, n);
    wait_sig(sel, 1, lim, n);
    chk(n, exp);
  endtask

  // request a measurement; lo below zero means it must be refused
  task automatic meas(input logic [7:0] d, input int lo, input int hi);
    int n;
    wr(ADDR_OSC, d);
    measReq = 1'b1;
    @(negedge sys_clk);
    measReq = 1'b0;
    wait_sig(0, 0, 700, n);
    if (lo < 0) begin
      chk({n, oscEnable}, {32'hFFFFFFFF, 1'b0});
    end else begin
      chk(n >= lo && n <= hi, 1'b1);
      @(negedge sys_clk);
      chk({measReady, oscEnable}, 2'b11);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    #(40000 * 100);
    n_fail++;
    end_sim();
  end

  initial begin
    logic [7:0] codes [4];
    int lo [4];
    int hi [4];
    codes = '{8'h01, 8'h06, 8'h03, 8'h02};
    lo = '{0, 0, 18, 598};
    hi = '{1, 26, 46, 626};
    // software keeps an internal hf source last, the trigger select at
    // zero with inversion set, and compensation only on floating sensors
    rows = '{'{4'h4, 8'h40, 8'h40}, '{4'h4, 8'h18, 8'h18},
             '{4'h5, 8'h3F, 8'h3F}, '{4'h6, 8'h04, 8'h04},
             '{4'h6, 8'h01, 8'h01}, '{4'h6, 8'h02, 8'h02},
             '{4'h7, 8'h0C, 8'h0C},
             '{4'h7, 8'h14, 8'h14},
             '{4'h8, 8'hE9, 8'hE9}, '{4'h8, 8'h5A, 8'h5A},
             '{4'h9, 8'h7C, 8'h7C}, '{4'h9, 8'h03, 8'h03},
             '{4'h9, 8'h42, 8'h42}, '{4'hA, 8'hA5, 8'hA5},
             '{4'h3, 8'hFF, 8'h00}, '{4'hB, 8'hFF, 8'h00}};
    n_fail = 0;
    cmp_count = 0;
    rst = 1'b1;
    cfgWrEn = 1'b0;
    cfgAddr = 4'h0;
    cfgWrData = 8'h00;
    extOscPin = 1'b0;
    lfClkPin = 1'b0;
    measReq = 1'b0;
    measDone = 1'b0;
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (16) @(negedge sys_clk);
    chk({measGo, measReady, oscEnable, oscGainHigh, oscTick, memClkEn,
         cfgRdData, feCtrl}, '0);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check_all();
    // ordinary cases: write, read back, decoded outputs follow
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
      chk({oscGainHigh, feCtrl},
          {sh[4][6], expFe()});
    end
    // refused requests: stop code, disabled continuous, disabled pulsed
    meas(8'h00, -1, 0);
    meas(8'h81, -1, 0);
    meas(8'h86, -1, 0);
    // granted requests with their warm-up spans
    for (int k = 0; k < 4; k++) begin
      meas(codes[k], lo[k], hi[k]);
      if (codes[k] == RUN_CONT) begin
        period(1, 8, 100);
        wr(ADDR_OSC, 8'h21);
        period(1, 32, 200);
        // disable mid-measurement must drop the oscillator at once
        wr(ADDR_OSC, 8'hA1);
        repeat (2) @(negedge sys_clk);
        chk({measReady, oscEnable}, 2'b00);
      end else begin
        measDone = 1'b1;
        @(negedge sys_clk);
        measDone = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({measReady, oscEnable}, 2'b00);
      end
    end
    // memory clock spacing: 20 cycles per lf period times divider
    wr(ADDR_MEMDIV, 8'h00);
    period(2, 20, 100);
    wr(ADDR_MEMDIV, 8'h01);
    period(2, 40, 200);
    wr(ADDR_MEMDIV, 8'h3F);
    period(2, 2520, 3000);
    // leave a working divider: 14 lf periods here, close to 35 kHz
    wr(ADDR_MEMDIV, 8'h07);
    period(2, 280, 400);
    // second reset in mid-run returns every register to zero
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({measGo, measReady, oscEnable, oscGainHigh, cfgRdData},
        '0);
    rst = 1'b0;
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (3) @(negedge sys_clk);
    check_all();
    end_sim();
  end
endmodule
